// ==== design/csi_pkg.sv ====
// Shared constants and carrier types for the counter unit status image
package csi_pkg;
	// Word indices of the input image, relative to the image base (n+14 = index 0x0E)
	localparam logic [5:0] IDX_OUT_LO = 6'h0E;
	localparam logic [5:0] IDX_OUT_HI = 6'h0F;
	localparam logic [5:0] IDX_INPUT = 6'h10;
	localparam logic [5:0] IDX_ERR1 = 6'h11;
	localparam logic [5:0] IDX_ERR2 = 6'h12;
	localparam logic [5:0] IDX_GENERAL = 6'h13;
	localparam logic [5:0] IDX_MASK_LO = 6'h14;
	localparam logic [5:0] IDX_MASK_HI = 6'h15;
	localparam logic [5:0] IDX_CNT_LO = 6'h16;
	localparam logic [5:0] IDX_CNT_HI = 6'h17;
	localparam logic [5:0] IDX_FLAGS = 6'h18;
	localparam logic [5:0] IDX_FIRST = 6'h0E;
	localparam logic [5:0] IDX_LAST = 6'h27;
	localparam int INPUT_WORDS = 26;
	// General flag word bit positions
	localparam int GB_GLOBAL_ERR = 0;
	localparam int GB_IRQ_PEND = 1;
	localparam int GB_XFER_BUSY = 2;
	localparam int GB_XFER_DONE = 3;
	localparam int GB_IA_OVERLAP = 4;
	// Counter flag word bit positions
	localparam int FB_OVERFLOW = 0;
	localparam int FB_UNDERFLOW = 1;
	localparam int FB_GATE_OPEN = 2;
	localparam int FB_DIR_UP = 3;
	localparam int FB_EVT_PRESET = 4;
	localparam int FB_EVT_RESET = 5;
	localparam int FB_EVT_CAPTURE = 6;
	localparam int FB_EVT_INDEX = 7;
	localparam int FB_RATE0 = 10;
	localparam int FB_RATE1 = 11;
	localparam int FB_SIMPLE = 15;
	localparam int EVT_COUNT = 4;
	localparam int ERR_DEPTH = 8;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;

	// Live state of the first counter channel
	typedef struct packed {
		logic [31:0] window_mask;
		logic [31:0] count;
		logic overflow;
		logic underflow;
		logic gate_open;
		logic dir_up;
		logic [3:0] events;
		logic rate0;
		logic rate1;
		logic simple;
	} csi_chan_t;

	// Live unit-wide state
	typedef struct packed {
		logic [31:0] outputs;
		logic [1:0] inputs;
		logic irq_pending;
		logic init_busy;
		logic xfer_busy;
		logic xfer_done;
		logic ia_overlap;
	} csi_unit_t;

	// One error list entry
	typedef struct packed {
		logic [15:0] code1;
		logic [15:0] code2;
	} csi_err_t;
endpackage

// ==== design/csi_event_latch.sv ====
// Per-event capture that stretches a pulse to exactly one host cycle
`timescale 1ns/1ns
`default_nettype none
module csi_event_latch #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Event and refresh
	input wire logic [N-1:0] evt_in,
	input wire logic refresh_in,
	// Stretched flags
	output logic [N-1:0] flag_out
);
	typedef struct packed {
		logic [N-1:0] seen;
		logic [N-1:0] shown;
	} csi_evl_state_t;

	csi_evl_state_t state_ff;
	csi_evl_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		for (int i = 0; i < N; i++) begin
			if (refresh_in) begin
				// Events seen since last refresh show for one host cycle
				nxt_state.shown[i] = state_ff.seen[i] | evt_in[i];
				nxt_state.seen[i] = 1'b0;
			end else if (evt_in[i]) begin
				nxt_state.seen[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flag_out = state_ff.shown;
endmodule
`default_nettype wire

// ==== design/csi_status_image.sv ====
// Status input word image of a two-channel counter unit, counter 1 group
//
// Overview of operation
// - Twenty-six input words: general group, then one group per counter.
// - Output status double word mirrors physical and soft outputs 0 to 31.
// - Input status word shows both digital input levels in bits 0-1.
// - Read-next-error rising edge advances list, shows next entry.
// - General bit 0 set while any error is recorded.
// - General bit 1 set while an interrupt waits in the queue.
// - General bit 2 high during block read/write or initialisation.
// - General bit 3 toggles each time a data transfer finishes.
// - General bit 4 set when indirect-address blocks overlap.
// - 32-bit mask, one bit per active range or comparison value.
// - Flag bit 0 set when linear counter reaches upper limit.
// - Flag bit 1 set when linear counter reaches lower limit.
// - Flag bit 2 shows gate open and counting.
// - Flag bit 3 shows count direction, 1 for up.
// - Event flags bits 4-7 stand exactly one host cycle per event.
// - Flag bits 10 and 11 show rate range 0 and 1.
// - Flag bit 15 reads 1 for simple counter configuration.
// - Simple counter: mask, rate flags and interrupt pending without function.
`timescale 1ns/1ns
`default_nettype none
module csi_status_image #(
	parameter int ERR_DEPTH = csi_pkg::ERR_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Host refresh and word read port
	input wire logic refresh_in,
	input wire logic [5:0] rd_addr_in,
	input wire logic read_next_error_in,
	// Host block transfer activity
	input wire logic host_block_read_instr_in,
	input wire logic host_block_write_instr_in,
	// Unit state
	input wire csi_pkg::csi_unit_t unit_in,
	input wire csi_pkg::csi_chan_t chan_in,
	// Error list fill
	input wire logic err_push_in,
	input wire csi_pkg::csi_err_t err_code_in,
	// Read data
	output logic [15:0] rd_data_out,
	output logic [15:0] general_flags_out,
	output logic [15:0] chan_flags_out
);
	localparam int PW = (ERR_DEPTH > 1) ? $clog2(ERR_DEPTH) : 1;
	localparam int CW = PW + 1;

	typedef struct packed {
		logic [31:0] outputs;
		logic [15:0] input_word;
		csi_pkg::csi_err_t err_shown;
		logic [15:0] general;
		logic [31:0] mask;
		logic [31:0] count;
		logic [15:0] flags;
		logic [15:0] rd_data;
		logic rne_prev;
		logic xfer_prev;
		logic xfer_done_tgl;
		logic [PW-1:0] err_rd;
		logic [PW-1:0] err_wr;
		logic [CW-1:0] err_cnt;
	} csi_state_t;

	csi_state_t state_ff;
	csi_state_t nxt_state;
	csi_pkg::csi_err_t err_mem [0:ERR_DEPTH-1];
	logic [3:0] evt_flags;
	logic xfer_active;
	logic rne_rise;
	logic err_pop;
	logic err_push_ok;

	csi_event_latch #(
		.N(csi_pkg::EVT_COUNT)
	) u_evt (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.evt_in(chan_in.events),
		.refresh_in(refresh_in),
		.flag_out(evt_flags)
	);

	assign xfer_active = host_block_read_instr_in | host_block_write_instr_in;
	assign rne_rise = read_next_error_in & ~state_ff.rne_prev;
	assign err_pop = rne_rise && (state_ff.err_cnt != '0);
	assign err_push_ok = err_push_in && (state_ff.err_cnt < CW'(ERR_DEPTH) || err_pop);

	// Error list storage
	always_ff @(posedge sys_clk_in) begin
		if (err_push_ok) begin
			err_mem[state_ff.err_wr] <= err_code_in;
		end
	end

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(ERR_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	always_comb begin
		logic [15:0] gen;
		logic [15:0] flg;
		csi_pkg::csi_err_t head;
		gen = csi_pkg::WORD_ZERO;
		flg = csi_pkg::WORD_ZERO;
		head = '0;
		nxt_state = state_ff;
		nxt_state.rne_prev = read_next_error_in;
		nxt_state.xfer_prev = xfer_active;
		if (state_ff.xfer_prev && !xfer_active) begin
			nxt_state.xfer_done_tgl = ~state_ff.xfer_done_tgl;
		end
		// Error list pointers
		if (err_push_ok) begin
			nxt_state.err_wr = ptr_inc(state_ff.err_wr);
		end
		if (err_pop) begin
			nxt_state.err_rd = ptr_inc(state_ff.err_rd);
			head = err_mem[state_ff.err_rd];
			nxt_state.err_shown = head;
		end
		if (err_push_ok && !err_pop) begin
			nxt_state.err_cnt = state_ff.err_cnt + CW'(1);
		end else if (err_pop && !err_push_ok) begin
			nxt_state.err_cnt = state_ff.err_cnt - CW'(1);
		end
		// General flag word
		gen[csi_pkg::GB_GLOBAL_ERR] = (state_ff.err_cnt != '0);
		gen[csi_pkg::GB_IRQ_PEND] = unit_in.irq_pending & ~chan_in.simple;
		gen[csi_pkg::GB_XFER_BUSY] = xfer_active | unit_in.init_busy;
		gen[csi_pkg::GB_XFER_DONE] = state_ff.xfer_done_tgl ^ unit_in.xfer_done;
		gen[csi_pkg::GB_IA_OVERLAP] = unit_in.ia_overlap;
		// Counter flag word
		flg[csi_pkg::FB_OVERFLOW] = chan_in.overflow & ~chan_in.simple;
		flg[csi_pkg::FB_UNDERFLOW] = chan_in.underflow & ~chan_in.simple;
		flg[csi_pkg::FB_GATE_OPEN] = chan_in.gate_open;
		flg[csi_pkg::FB_DIR_UP] = chan_in.dir_up;
		flg[csi_pkg::FB_EVT_PRESET] = evt_flags[0];
		flg[csi_pkg::FB_EVT_RESET] = evt_flags[1];
		flg[csi_pkg::FB_EVT_CAPTURE] = evt_flags[2];
		flg[csi_pkg::FB_EVT_INDEX] = evt_flags[3];
		flg[csi_pkg::FB_RATE0] = chan_in.rate0 & ~chan_in.simple;
		flg[csi_pkg::FB_RATE1] = chan_in.rate1 & ~chan_in.simple;
		flg[csi_pkg::FB_SIMPLE] = chan_in.simple;
		nxt_state.general = gen;
		nxt_state.flags = flg;
		// Image words latch at the host refresh
		if (refresh_in) begin
			nxt_state.outputs = unit_in.outputs;
			nxt_state.input_word = {14'h0000, unit_in.inputs};
			nxt_state.mask = chan_in.simple ? csi_pkg::DWORD_ZERO : chan_in.window_mask;
			nxt_state.count = chan_in.count;
		end
		// Word read decode; anything outside words 0x0E to 0x18 reads zero
		unique case (rd_addr_in)
			csi_pkg::IDX_OUT_LO: nxt_state.rd_data = state_ff.outputs[15:0];
			csi_pkg::IDX_OUT_HI: nxt_state.rd_data = state_ff.outputs[31:16];
			csi_pkg::IDX_INPUT: nxt_state.rd_data = state_ff.input_word;
			csi_pkg::IDX_ERR1: nxt_state.rd_data = state_ff.err_shown.code1;
			csi_pkg::IDX_ERR2: nxt_state.rd_data = state_ff.err_shown.code2;
			csi_pkg::IDX_GENERAL: nxt_state.rd_data = state_ff.general;
			csi_pkg::IDX_MASK_LO: nxt_state.rd_data = state_ff.mask[15:0];
			csi_pkg::IDX_MASK_HI: nxt_state.rd_data = state_ff.mask[31:16];
			csi_pkg::IDX_CNT_LO: nxt_state.rd_data = state_ff.count[15:0];
			csi_pkg::IDX_CNT_HI: nxt_state.rd_data = state_ff.count[31:16];
			csi_pkg::IDX_FLAGS: nxt_state.rd_data = state_ff.flags;
			default: nxt_state.rd_data = csi_pkg::WORD_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign rd_data_out = state_ff.rd_data;
	assign general_flags_out = state_ff.general;
	assign chan_flags_out = state_ff.flags;
endmodule
`default_nettype wire

// ==== test/csi_status_image_monitor.sv ====
// Port checker for the counter unit status image
`timescale 1ns/1ns
`default_nettype none
module csi_status_image_monitor #(
	parameter int ERR_DEPTH = 8
) (
	// Design inputs
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic refresh_in,
	input wire logic [5:0] rd_addr_in,
	input wire logic read_next_error_in,
	input wire logic host_block_read_instr_in,
	input wire logic host_block_write_instr_in,
	input wire csi_pkg::csi_unit_t unit_in,
	input wire csi_pkg::csi_chan_t chan_in,
	input wire logic err_push_in,
	input wire csi_pkg::csi_err_t err_code_in,
	// Design outputs
	input wire logic [15:0] rd_data_out,
	input wire logic [15:0] general_flags_out,
	input wire logic [15:0] chan_flags_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence xfer_end;
		(host_block_read_instr_in || host_block_write_instr_in) ##1
			!(host_block_read_instr_in || host_block_write_instr_in);
	endsequence
	chk_gate_flag: assert property ($past(nrst_in) |-> chan_flags_out[2] == $past(chan_in.gate_open))
		else $error("gate flag wrong");
	chk_dir_flag: assert property ($past(nrst_in) |-> chan_flags_out[3] == $past(chan_in.dir_up))
		else $error("direction flag wrong");
	chk_simple_flag: assert property ($past(nrst_in) |->
		chan_flags_out[15] == $past(chan_in.simple))
		else $error("simple counter flag wrong");
	chk_simple_rate: assert property (chan_flags_out[15] |-> chan_flags_out[11:10] == 2'b00)
		else $error("rate flags set in simple mode");
	chk_unused_zero: assert property (chan_flags_out[9:8] == 2'b00
		&& chan_flags_out[14:12] == 3'h0 && general_flags_out[15:5] == 11'h000)
		else $error("unused flag bit set");
	chk_busy_flag: assert property ($past(nrst_in) |->
		general_flags_out[2] == ($past(unit_in.init_busy) || $past(host_block_read_instr_in)
		|| $past(host_block_write_instr_in)))
		else $error("busy flag wrong");
	chk_done_toggle: assert property (xfer_end |-> ##[0:2] $changed(general_flags_out[3]))
		else $error("done bit did not toggle");
	chk_error_flag: assert property (err_push_in |-> ##2 general_flags_out[0])
		else $error("global error not set");
	chk_unmapped_read: assert property (rd_addr_in > csi_pkg::IDX_FLAGS |=> rd_data_out == 16'h0000)
		else $error("unmapped word not zero");
	chk_input_upper: assert property (rd_addr_in == csi_pkg::IDX_INPUT |=> rd_data_out[15:2] == 14'h0)
		else $error("input word upper bits set");
endmodule
bind csi_status_image csi_status_image_monitor #(.ERR_DEPTH(ERR_DEPTH)) i_csi_status_image_monitor (
	.sys_clk_in, .nrst_in, .refresh_in, .rd_addr_in, .read_next_error_in, .host_block_read_instr_in,
	.host_block_write_instr_in, .unit_in, .chan_in, .err_push_in, .err_code_in, .rd_data_out,
	.general_flags_out, .chan_flags_out);
`default_nettype wire

// ==== test/csi_host_model.sv ====
// Host controller model issuing one I/O refresh per host cycle
`timescale 1ns/1ns
`default_nettype none
module csi_host_model #(
	parameter int PERIOD = 8
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// Refresh pulse
	output logic refresh_out
);
	int cnt = 0;
	initial refresh_out = 1'b0;
	always @(posedge sys_clk_in) begin
		cnt <= (!nrst_in || cnt == PERIOD - 1) ? 0 : cnt + 1;
		refresh_out <= nrst_in && cnt == PERIOD - 1;
	end
endmodule
`default_nettype wire

// ==== test/csi_status_image_tb.sv ====
// Self-checking testbench for the counter unit status image
`timescale 1ns/1ns
`default_nettype none
module csi_status_image_tb;
	localparam int PER = 8;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic refresh_in;
	logic [5:0] rd_addr_in = 6'h00;
	logic read_next_error_in = 1'b0;
	logic host_block_read_instr_in = 1'b0;
	logic host_block_write_instr_in = 1'b0;
	csi_pkg::csi_unit_t unit_in = '0;
	csi_pkg::csi_chan_t chan_in = '0;
	logic err_push_in = 1'b0;
	csi_pkg::csi_err_t err_code_in = '0;
	logic [15:0] rd_data_out, general_flags_out, chan_flags_out;
	int err_count = 0;
	int n_checks = 0;
	int hits;
	logic [21:0] img [9] = '{22'h0E0F12, 22'h0FA5C3, 22'h100002, 22'h140001, 22'h158000,
		22'h16FEDC, 22'h171234, 22'h190000, 22'h270000};
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	csi_host_model #(.PERIOD(PER)) i_csi_host_model (.sys_clk_in, .nrst_in, .refresh_out(refresh_in));
	csi_status_image i_csi_status_image (.sys_clk_in, .nrst_in, .refresh_in, .rd_addr_in,
		.read_next_error_in, .host_block_read_instr_in, .host_block_write_instr_in, .unit_in,
		.chan_in, .err_push_in, .err_code_in, .rd_data_out, .general_flags_out, .chan_flags_out);
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		rd_addr_in <= a;
		tick(1);
		#1 chk("rd_data_out", rd_data_out, exp);
		tick(1);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#200000 err_count++;
		tally_and_finish;
	end
	initial begin
		tick(2);
		nrst_in <= 1'b1;
		tick(1);
		unit_in.outputs <= 32'hA5C3_0F12;
		unit_in.inputs <= 2'b10;
		chan_in.window_mask <= 32'h8000_0001;
		chan_in.count <= 32'h1234_FEDC;
		tick(PER + 1);
		foreach (img[i]) rd(img[i][21:16], img[i][15:0]);
		$display("Test image done");
		err_code_in <= '{16'hE101, 16'hE102};
		err_push_in <= 1'b1;
		tick(1);
		err_code_in <= '{16'hE201, 16'hE202};
		tick(1);
		err_push_in <= 1'b0;
		tick(2);
		#1 chk("general", general_flags_out, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			tick(1);
			read_next_error_in <= 1'b1;
			tick(1);
			read_next_error_in <= 1'b0;
			tick(2);
			rd(6'h11, i ? 16'hE201 : 16'hE101);
			rd(6'h12, i ? 16'hE202 : 16'hE102);
		end
		tick(2);
		#1 chk("general", general_flags_out, 16'h0000);
		$display("Test errors done");
		tick(1);
		chan_in <= '{32'h0, 32'h0, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 1'b1, 1'b0, 1'b0};
		tick(2);
		#1 chk("flags", chan_flags_out, 16'h040D);
		tick(1);
		chan_in <= '{32'h0, 32'h0, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 1'b0, 1'b1, 1'b1};
		unit_in.irq_pending <= 1'b1;
		unit_in.ia_overlap <= 1'b1;
		tick(2);
		#1 chk("flags", chan_flags_out, 16'h800C);
		chk("general", general_flags_out, 16'h0010);
		tick(1);
		chan_in <= '{32'h0, 32'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0};
		tick(2);
		#1 chk("flags", chan_flags_out, 16'h0802);
		chk("general", general_flags_out, 16'h0012);
		tick(1);
		rd(csi_pkg::IDX_GENERAL, 16'h0012);
		rd(csi_pkg::IDX_FLAGS, 16'h0802);
		chan_in.events <= 4'hF;
		tick(1);
		chan_in.events <= 4'h0;
		hits = 0;
		repeat (3 * PER) begin
			tick(1);
			#1 hits += int'(chan_flags_out[7:4] === 4'hF);
		end
		chk("event_cycles", 16'(hits), 16'(PER));
		$display("Test flags done");
		tick(1);
		host_block_read_instr_in <= 1'b1;
		tick(3);
		#1 chk("busy", general_flags_out & 16'h000C, 16'h0004);
		tick(1);
		host_block_read_instr_in <= 1'b0;
		tick(3);
		#1 chk("done", general_flags_out & 16'h000C, 16'h0008);
		tick(1);
		host_block_write_instr_in <= 1'b1;
		tick(1);
		host_block_write_instr_in <= 1'b0;
		unit_in.init_busy <= 1'b1;
		tick(3);
		#1 chk("init", general_flags_out & 16'h000C, 16'h0004);
		$display("Test transfer done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
